// *** hdl/ihb_interrupt_ctrl.sv ***
// eight-source interrupt controller with heartbeat timer
`timescale 1ns/1ps
`default_nettype none

module ihb_interrupt_ctrl
    import ihb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire ihb_reg_req_t reg_req_in,
    input wire logic ack_in,
    input wire logic return_in,
    input wire logic [3:0] code_bank_in,
    input wire logic timer1_ovf_in,
    input wire logic timer2_ovf_in,
    input wire logic timer3_ovf_in,
    input wire logic filter_end_in,
    input wire logic block_end_in,
    input wire logic ext_request_pin_a_in,
    input wire logic ext_request_pin_b_in,
    input wire logic primary_clock_in,
    output logic [7:0] reg_rdata_out,
    output logic int_req_out,
    output ihb_vector_t vector_out,
    output logic [7:0] status_word_out,
    output logic [7:0] system_control_out,
    output logic [7:0] clock_extension_out,
    output logic [7:0] third_timer_control_out
);

    // true on the selected edge of a pin: sel 0 rising, 1 falling
    function automatic logic edge_match(input logic prev, input logic cur, input logic sel);
        edge_match = sel ? (prev & ~cur) : (~prev & cur);
    endfunction : edge_match

    // index of the lowest set bit
    function automatic logic [2:0] lowest_index(input logic [7:0] v);
        lowest_index = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                lowest_index = i[2:0];
            end
        end
    endfunction : lowest_index

    logic [7:0] status_word;
    logic [7:0] saved_status_word;
    logic [7:0] system_control;
    logic [7:0] clock_extension;
    logic [7:0] third_timer_control;
    logic [7:0] request_mask;
    logic [7:0] pending_requests;
    logic [7:0] src_prev;
    logic [7:0] src_raw;
    logic [7:0] src_set;
    logic [7:0] next_pending;
    logic [7:0] next_status;
    logic [7:0] next_mask;
    logic [7:0] next_active;
    logic [13:0] hb_count;
    logic hb_tick;
    logic clk_prev;
    logic wr_saved, wr_system_control, wr_clock_extension, wr_third_timer_control, wr_mask, wr_pend, wr_status;

    // address decode of register writes
    assign wr_saved = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_SAVED);
    assign wr_system_control = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_SYSTEM_CONTROL);
    assign wr_clock_extension = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_CLOCK_EXTENSION);
    assign wr_third_timer_control = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_THIRD_TIMER_CONTROL);
    assign wr_mask = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_MASK);
    assign wr_pend = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_PEND);
    assign wr_status = reg_req_in.wr && (reg_req_in.addr == IHB_ADDR_STATUS);

    // heartbeat: count primary clock rising edges while its clock bit is on
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_prev <= 1'b0;
            hb_count <= 14'h0000;
            hb_tick <= 1'b0;
        end else begin
            clk_prev <= primary_clock_in;
            hb_tick <= 1'b0;
            if (!clock_extension[IHB_HB_ON_BIT]) begin
                hb_count <= 14'h0000;
            end else if (primary_clock_in && !clk_prev) begin
                if (hb_count == IHB_HB_LAST) begin
                    hb_count <= 14'h0000;
                    hb_tick <= 1'b1;
                end else begin
                    hb_count <= hb_count + 14'h0001;
                end
            end
        end
    end

    // raw source levels in request-number order; third timer gated by its on bit
    assign src_raw = {hb_tick, ext_request_pin_b_in, block_end_in,
                      timer3_ovf_in & third_timer_control[IHB_THIRD_TIMER_ON_BIT],
                      ext_request_pin_a_in, filter_end_in, timer2_ovf_in, timer1_ovf_in};

    // edge capture: pins follow their edge selects, the rest are rising edges
    always_comb begin
        src_set = src_raw & ~src_prev;
        src_set[IHB_SRC_PIN_A] = edge_match(src_prev[IHB_SRC_PIN_A], src_raw[IHB_SRC_PIN_A],
                                            system_control[IHB_EDGE_A_BIT]);
        src_set[IHB_SRC_PIN_B] = edge_match(src_prev[IHB_SRC_PIN_B], src_raw[IHB_SRC_PIN_B],
                                            system_control[IHB_EDGE_B_BIT]);
    end

    // previous source levels for edge detection
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            src_prev <= 8'h00;
        end else begin
            src_prev <= src_raw;
        end
    end

    // pending flags: write zero clears, a new edge in the same cycle wins
    always_comb begin
        next_pending = pending_requests;
        if (wr_pend) begin
            next_pending = pending_requests & reg_req_in.wdata;
        end
        next_pending = next_pending | src_set;
    end

    // next status word: write, return reload, acknowledge clears enable
    always_comb begin
        next_status = wr_status ? reg_req_in.wdata : status_word;
        if (return_in) begin
            next_status = saved_status_word;
        end
        if (ack_in) begin
            next_status[IHB_GIE_BIT] = 1'b0;
        end
    end

    assign next_mask = wr_mask ? reg_req_in.wdata : request_mask;
    assign next_active = next_pending & next_mask;

    // request, mask and configuration registers
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pending_requests <= IHB_RST_REG;
            request_mask <= IHB_RST_REG;
            system_control <= IHB_RST_REG;
            clock_extension <= IHB_RST_REG;
            third_timer_control <= IHB_RST_REG;
        end else begin
            pending_requests <= next_pending;
            request_mask <= next_mask;
            if (wr_system_control) begin
                system_control <= reg_req_in.wdata;
            end
            if (wr_clock_extension) begin
                clock_extension <= reg_req_in.wdata;
            end
            if (wr_third_timer_control) begin
                third_timer_control <= reg_req_in.wdata;
            end
        end
    end

    // status word and its saved copy
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_word <= IHB_RST_REG;
            saved_status_word <= IHB_RST_REG;
        end else begin
            status_word <= next_status;
            if (ack_in) begin
                // copy includes a same-cycle write, so a cleared enable stays cleared
                saved_status_word <= wr_status ? reg_req_in.wdata : status_word;
            end else if (wr_saved) begin
                saved_status_word <= reg_req_in.wdata;
            end else if (wr_status) begin
                saved_status_word[IHB_GIE_BIT] <= reg_req_in.wdata[IHB_GIE_BIT];
            end
        end
    end

    // interrupt request and vector, lowest number first
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_req_out <= 1'b0;
            vector_out <= '0;
        end else begin
            int_req_out <= next_status[IHB_GIE_BIT] && (next_active != 8'h00);
            vector_out.bank <= code_bank_in;
            vector_out.offset <= IHB_VEC_BASE + IHB_VEC_STEP * {13'h0000, lowest_index(next_active)};
        end
    end

    // read data, one cycle after the address; timer control and unmapped read zero
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            unique case (reg_req_in.addr)
                IHB_ADDR_SAVED: reg_rdata_out <= saved_status_word;
                IHB_ADDR_SYSTEM_CONTROL: reg_rdata_out <= system_control;
                IHB_ADDR_CLOCK_EXTENSION: reg_rdata_out <= clock_extension;
                IHB_ADDR_MASK: reg_rdata_out <= request_mask;
                IHB_ADDR_PEND: reg_rdata_out <= pending_requests;
                IHB_ADDR_STATUS: reg_rdata_out <= status_word;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // register copies to the core and timers
    assign status_word_out = status_word;
    assign system_control_out = system_control;
    assign clock_extension_out = clock_extension;
    assign third_timer_control_out = third_timer_control;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_ack;
        ack_in && !return_in && !reg_req_in.wr;
    endsequence

    sequence s_return;
        return_in && !ack_in && !reg_req_in.wr;
    endsequence

    property p_int_gate;
        int_req_out |-> status_word[IHB_GIE_BIT] && ((pending_requests & request_mask) != 8'h00);
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("request raised without flag, mask and enable");

    property p_ack_save;
        s_ack |=> !status_word[IHB_GIE_BIT] && (saved_status_word == $past(status_word)) && !int_req_out;
    endproperty
    a_ack_save: assert property (p_ack_save) else $error("acknowledge did not save status and block");

    property p_return;
        s_return |=> status_word == $past(saved_status_word);
    endproperty
    a_return: assert property (p_return) else $error("return did not reload status");

    // acknowledge in the cycle of an enable-clearing write: the saved copy keeps the cleared enable
    property p_nest_cli;
        (ack_in && !return_in && wr_status && !reg_req_in.wdata[IHB_GIE_BIT])
            |=> !saved_status_word[IHB_GIE_BIT] && !status_word[IHB_GIE_BIT];
    endproperty
    a_nest_cli: assert property (p_nest_cli) else $error("enable came back after cleared-enable interrupt");

    property p_shadow;
        (wr_status && !ack_in && !return_in) |=> saved_status_word[IHB_GIE_BIT] == status_word[IHB_GIE_BIT];
    endproperty
    a_shadow: assert property (p_shadow) else $error("enable write not copied to saved status");

    property p_no_sw_set;
        ##1 ((pending_requests & ~$past(pending_requests) & ~$past(src_set)) == 8'h00);
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("pending flag set without a source edge");

    property p_clear;
        (wr_pend && (src_set == 8'h00)) |=> pending_requests == ($past(pending_requests) & $past(reg_req_in.wdata));
    endproperty
    a_clear: assert property (p_clear) else $error("pending write did not clear by zeros");

    property p_vector;
        int_req_out |-> vector_out.offset ==
            IHB_VEC_BASE + IHB_VEC_STEP * {13'h0000, lowest_index(pending_requests & request_mask)};
    endproperty
    a_vector: assert property (p_vector) else $error("vector not lowest pending request");

    property p_hb_tick;
        hb_tick |-> $past(hb_count) == IHB_HB_LAST && hb_count == 14'h0000;
    endproperty
    a_hb_tick: assert property (p_hb_tick) else $error("heartbeat tick off its interval");

    property p_hb_off;
        !clock_extension[IHB_HB_ON_BIT] |=> !hb_tick && hb_count == 14'h0000;
    endproperty
    a_hb_off: assert property (p_hb_off) else $error("heartbeat runs while powered down");

    property p_t3_off;
        !third_timer_control[IHB_THIRD_TIMER_ON_BIT] |-> !src_set[IHB_SRC_T3];
    endproperty
    a_t3_off: assert property (p_t3_off) else $error("third timer request while powered down");

    property p_pin_edge;
        src_set[IHB_SRC_PIN_A] |-> (src_raw[IHB_SRC_PIN_A] == !system_control[IHB_EDGE_A_BIT]);
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin request on the wrong edge");

endmodule : ihb_interrupt_ctrl

`default_nettype wire

// *** hdl/ihb_pkg.sv ***
// constants and carrier types for the interrupt controller and heartbeat timer
package ihb_pkg;
    // register addresses on the processor register port
    localparam logic [7:0] IHB_ADDR_SAVED = 8'hcf;
    localparam logic [7:0] IHB_ADDR_SYSTEM_CONTROL = 8'hd5;
    localparam logic [7:0] IHB_ADDR_CLOCK_EXTENSION = 8'hd6;
    localparam logic [7:0] IHB_ADDR_THIRD_TIMER_CONTROL = 8'hd9;
    localparam logic [7:0] IHB_ADDR_MASK = 8'hfd;
    localparam logic [7:0] IHB_ADDR_PEND = 8'hfe;
    localparam logic [7:0] IHB_ADDR_STATUS = 8'hff;
    // reset values
    localparam logic [7:0] IHB_RST_REG = 8'h00;
    // request source bit positions
    localparam int IHB_SRC_T1 = 0;
    localparam int IHB_SRC_T2 = 1;
    localparam int IHB_SRC_FILTER = 2;
    localparam int IHB_SRC_PIN_A = 3;
    localparam int IHB_SRC_T3 = 4;
    localparam int IHB_SRC_BLOCK = 5;
    localparam int IHB_SRC_PIN_B = 6;
    localparam int IHB_SRC_HB = 7;
    // field positions
    localparam int IHB_GIE_BIT = 0;
    localparam int IHB_EDGE_A_BIT = 0;
    localparam int IHB_EDGE_B_BIT = 1;
    localparam int IHB_HB_ON_BIT = 6;
    localparam int IHB_THIRD_TIMER_ON_BIT = 7;
    // heartbeat: fixed divide of the primary clock (858.1 us at 14.32 MHz)
    localparam logic [13:0] IHB_HB_DIVIDE = 14'h3000;
    localparam logic [13:0] IHB_HB_LAST = IHB_HB_DIVIDE - 14'h0001;
    // vector table: base plus four per request number
    localparam logic [15:0] IHB_VEC_BASE = 16'h0004;
    localparam logic [15:0] IHB_VEC_STEP = 16'h0004;

    // one register-port access from the core
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ihb_reg_req_t;

    // 20-bit interrupt vector
    typedef struct packed {
        logic [3:0] bank;
        logic [15:0] offset;
    } ihb_vector_t;
endpackage : ihb_pkg

// *** bench/ihb_core_model.sv ***
// behavioural processor core: takes interrupts and returns after a handler delay
`timescale 1ns/1ps
`default_nettype none
module ihb_core_model (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic int_req_in,
    input wire logic enable_in,
    input wire logic [7:0] handler_len_in,
    output logic ack_out,
    output logic return_out
);
    logic busy;
    logic [7:0] cnt;
    // acknowledge only a raised request, then return once the handler ends
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_out <= 1'b0;
            return_out <= 1'b0;
            busy <= 1'b0;
            cnt <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            return_out <= 1'b0;
            if (!busy && !ack_out && !return_out && enable_in && int_req_in) begin
                ack_out <= 1'b1;
                busy <= 1'b1;
                cnt <= handler_len_in;
            end else if (busy && cnt != 8'h00) begin
                cnt <= cnt - 8'h01; // handler leaves saved status as found
            end else if (busy && !ack_out) begin
                return_out <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule : ihb_core_model
`default_nettype wire

// *** bench/ihb_interrupt_ctrl_tb.sv ***
// self-checking bench for the interrupt controller and heartbeat timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module ihb_interrupt_ctrl_tb
    import ihb_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ihb_row_t;
    ihb_row_t rows [8] = '{'{8'hcf, 8'h5a, 8'h5a}, '{8'hd5, 8'h03, 8'h03}, '{8'hd6, 8'h00, 8'h00},
        '{8'hd9, 8'h80, 8'h00}, '{8'hfd, 8'h5a, 8'h5a}, '{8'hfe, 8'hff, 8'h00},
        '{8'h10, 8'h55, 8'h00}, '{8'hff, 8'h00, 8'h00}};
    logic clk_sys_in, reset_n_in, ack, ret, pclk, irq, core_en;
    ihb_reg_req_t req;
    logic [6:0] src;
    logic [3:0] bank;
    logic [7:0] hlen, rdata, status, sysc, clkx, t3c;
    ihb_vector_t vec;
    int miscompares, checked, cycles;
    ihb_interrupt_ctrl ihb_interrupt_ctrl_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .reg_req_in(req), .ack_in(ack), .return_in(ret), .code_bank_in(bank), .timer1_ovf_in(src[0]),
        .timer2_ovf_in(src[1]), .timer3_ovf_in(src[4]), .filter_end_in(src[2]), .block_end_in(src[5]),
        .ext_request_pin_a_in(src[3]), .ext_request_pin_b_in(src[6]), .primary_clock_in(pclk),
        .reg_rdata_out(rdata), .int_req_out(irq), .vector_out(vec), .status_word_out(status),
        .system_control_out(sysc), .clock_extension_out(clkx), .third_timer_control_out(t3c));
    ihb_core_model ihb_core_model_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .int_req_in(irq), .enable_in(core_en), .handler_len_in(hlen), .ack_out(ack), .return_out(ret));
    // verdict and end of run
    task automatic test_done;
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // one register write, then let it land
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, a, d};
        @(negedge clk_sys_in);
        req.wr = 1'b0;
        @(negedge clk_sys_in);
    endtask : wr
    // read a register one cycle after presenting its address
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        req.addr = a;
        @(negedge clk_sys_in);
        `CHK("register", e, rdata)
    endtask : chk_reg
    // set source levels, then wait two cycles
    task automatic lev(input logic [6:0] v);
        src = v;
        repeat (2) @(negedge clk_sys_in);
    endtask : lev
    // primary clock rises, four system cycles each
    task automatic rises(input int n);
        for (int k = 0; k < n; k++) begin
            pclk = 1'b1;
            repeat (2) @(negedge clk_sys_in);
            pclk = 1'b0;
            repeat (2) @(negedge clk_sys_in);
        end
    endtask : rises
    // system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            test_done();
        end
    end
    // main sequence
    initial begin
        int i;
        reset_n_in = 1'b0;
        req = '0;
        src = 7'h00;
        pclk = 1'b0;
        core_en = 1'b0;
        hlen = 8'h14;
        bank = 4'h5;
        repeat (12) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        for (i = 0; i < 8; i++) chk_reg(rows[i].a, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].d);
            chk_reg(rows[i].a, rows[i].e);
        end
        // register copies to the core and timers
        `CHK("system_control_out", 8'h03, sysc)
        `CHK("clock_extension_out", 8'h00, clkx)
        `CHK("third_timer_control_out", 8'h80, t3c)
        // masked flags, priority and vectors
        wr(IHB_ADDR_MASK, 8'h00);
        wr(IHB_ADDR_STATUS, 8'h01);
        chk_reg(IHB_ADDR_SAVED, 8'h5b);
        lev(7'h03);
        lev(7'h00);
        chk_reg(IHB_ADDR_PEND, 8'h03);
        `CHK("irq", 1'b0, irq)
        wr(IHB_ADDR_MASK, 8'h03);
        `CHK("irq", 1'b1, irq)
        `CHK("vector", 20'h50004, vec)
        wr(IHB_ADDR_MASK, 8'h02);
        `CHK("vector", 20'h50008, vec)
        chk_reg(IHB_ADDR_PEND, 8'h03);
        // acknowledge and return through the core model
        core_en = 1'b1;
        for (i = 0; i < 40 && ack !== 1'b1; i++) @(negedge clk_sys_in);
        core_en = 1'b0;
        @(negedge clk_sys_in);
        `CHK("status", 8'h00, status)
        `CHK("irq", 1'b0, irq)
        chk_reg(IHB_ADDR_SAVED, 8'h01);
        for (i = 0; i < 40 && ret !== 1'b1; i++) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK("status", 8'h01, status)
        `CHK("irq", 1'b1, irq)
        // acknowledge lands in the same cycle as a write that clears the enable
        core_en = 1'b1;
        for (i = 0; i < 40 && ack !== 1'b1; i++) @(negedge clk_sys_in);
        core_en = 1'b0;
        wr(IHB_ADDR_STATUS, 8'h00);
        chk_reg(IHB_ADDR_SAVED, 8'h00);
        for (i = 0; i < 40 && ret !== 1'b1; i++) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK("status", 8'h00, status)
        `CHK("irq", 1'b0, irq)
        wr(IHB_ADDR_STATUS, 8'h01);
        `CHK("irq", 1'b1, irq)
        wr(IHB_ADDR_PEND, 8'hfd);
        `CHK("irq", 1'b0, irq)
        chk_reg(IHB_ADDR_PEND, 8'h01);
        // external pin edges
        wr(IHB_ADDR_PEND, 8'h00);
        wr(IHB_ADDR_SYSTEM_CONTROL, 8'h01);
        lev(7'h08);
        chk_reg(IHB_ADDR_PEND, 8'h00);
        lev(7'h00);
        chk_reg(IHB_ADDR_PEND, 8'h08);
        lev(7'h40);
        lev(7'h00);
        chk_reg(IHB_ADDR_PEND, 8'h48);
        // third timer power down
        wr(IHB_ADDR_PEND, 8'h00);
        wr(IHB_ADDR_THIRD_TIMER_CONTROL, 8'h00);
        `CHK("third_timer_control_out", 8'h00, t3c)
        lev(7'h10);
        lev(7'h00);
        chk_reg(IHB_ADDR_PEND, 8'h00);
        wr(IHB_ADDR_THIRD_TIMER_CONTROL, 8'h80);
        lev(7'h10);
        lev(7'h00);
        chk_reg(IHB_ADDR_PEND, 8'h10);
        // heartbeat: gated rises must not count
        wr(IHB_ADDR_PEND, 8'h00);
        rises(100);
        wr(IHB_ADDR_CLOCK_EXTENSION, 8'h40);
        `CHK("clock_extension_out", 8'h40, clkx)
        rises(12287);
        chk_reg(IHB_ADDR_PEND, 8'h00);
        rises(1);
        chk_reg(IHB_ADDR_PEND, 8'h80);
        // mid-run reset clears flags and powers the heartbeat down
        reset_n_in = 1'b0;
        @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        `CHK("clock_extension_out", 8'h00, clkx)
        `CHK("status", 8'h00, status)
        chk_reg(IHB_ADDR_PEND, 8'h00);
        test_done();
    end
endmodule : ihb_interrupt_ctrl_tb
`default_nettype wire
